// [core/link_cfg.svh]
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH
// ==========================================================
// Link control codes
`define B_DLE        8'h10
`define B_SOH        8'h01
`define B_STX        8'h02
`define B_ETX        8'h03
`define B_ENQ        8'h05
`define B_ODD        8'h11
`define B_EVEN       8'h12
`define B_NAK        8'h15
`define B_SYN        8'h16
`define B_PAD        8'hFE
// ==========================================================
// Route digit coding
`define HEX_0        8'h30
`define HEX_9        8'h39
`define HEX_A        8'h41
`define HEX_F        8'h46
`define HEX_NUM_BASE 8'h30
`define HEX_LET_BASE 8'h37
`define NIB_TEN      4'hA
// ==========================================================
// Sizes
`define MAX_DATA_LEN 295
`define MAX_DROPS    8
`define FIFO_WORDS   16
`define SUM_ZERO     8'h00
`endif

// [core/link_pkg.sv]
package link_pkg;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } snd_word_s;

  // ==========================================================
  // States
  typedef enum {
    T_IDLE, T_SOH, T_TAG, T_RTH, T_RTL, T_STX0, T_STX,
    T_DAT, T_ESC, T_ETX0, T_ETX, T_CSUM, T_PAD, T_RSP
  } tx_state_e;

  typedef enum {R_IDLE, R_TAG, R_ROUTE, R_DATA, R_CSUM} rx_state_e;
endpackage

// [core/csum_acc.sv]
`timescale 1ns/100ps
module csum_acc (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] din,
  // Running sum
  output logic      [7:0] sum_q
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sum_q <= 8'h00;
    end else if (clr) begin
      sum_q <= 8'h00;
    end else if (add) begin
      sum_q <= 8'(sum_q + din);
    end
  end
endmodule // csum_acc

// [core/byte_fifo.sv]
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // Storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // ==========================================================
  // Pointers and fill count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule // byte_fifo

// [core/p2p_link_frame_codec.sv]
`timescale 1ns/100ps
`include "link_cfg.svh"
module p2p_link_frame_codec
  import link_pkg::*;
#(
  parameter int MAX_DATA   = `MAX_DATA_LEN,
  parameter int MAX_DROPS  = `MAX_DROPS,
  parameter int FIFO_DEPTH = `FIFO_WORDS
)(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Outgoing data words
  input  wire logic                   snd_valid,
  output logic                        snd_ready,
  input  wire snd_word_s              snd_word,
  input  wire logic [8*MAX_DROPS-1:0] route_drops,
  input  wire logic [3:0]             route_cnt,
  // Outgoing frame outcome
  output logic                        outstanding_q,
  output logic                        tx_done_q,
  output logic                        tx_rejected_q,
  output logic                        tx_held_q,
  // Byte stream to transmitter
  output logic [7:0]                  tx_byte_q,
  output logic                        tx_valid_q,
  input  wire logic                   tx_ready,
  // Byte stream from receiver
  input  wire logic [7:0]             rx_byte,
  input  wire logic                   rx_valid,
  input  wire logic                   rx_fault,
  // Incoming data
  input  wire logic                   hold_req,
  output logic [7:0]                  rcv_data_q,
  output logic                        rcv_valid_q,
  output logic                        rcv_end_q,
  output logic                        rcv_good_q
);
  // ==========================================================
  // Helpers
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < `NIB_TEN) ? 8'(`HEX_NUM_BASE + n) : 8'(`HEX_LET_BASE + n);
  endfunction

  function automatic logic is_hex(input logic [7:0] b);
    is_hex = (b >= `HEX_0 && b <= `HEX_9) || (b >= `HEX_A && b <= `HEX_F);
  endfunction

  // ==========================================================
  // Declarations
  tx_state_e                ts_q, ns, ret_q;
  rx_state_e                rs_q, r_ns;
  snd_word_s                fw;
  logic                     fv, fifo_rdy;
  logic [7:0]               nb, tsum, rsum, rdin, tag_byte, resp_code_q, last_q;
  logic                     nv, cov, pop, rsp_sent, rt_step, start, step, can_load;
  logic                     tag_q, resp_pend_q, esc_q, esc_d, rtag_q;
  logic [8*MAX_DROPS-1:0]   rte_q;
  logic [3:0]               rcnt_q, rt_idx_q;
  logic [4:0]               rtc_q;
  logic [8:0]               rlen_q;
  logic                     fail, good, hold, dv, rsp_seen, qry, radd, rclr, rtag_d;
  logic                     rsp_set;
  logic [7:0]               rsp_new;

  // ==========================================================
  // Outgoing word buffer
  byte_fifo #(
    .W     ($bits(snd_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (snd_valid),
    .in_ready  (snd_ready),
    .in_data   (snd_word),
    .out_valid (fv),
    .out_ready (fifo_rdy),
    .out_data  (fw)
  );

  assign can_load = !tx_valid_q || tx_ready;
  assign step     = can_load && nv;
  assign fifo_rdy = step && pop;
  assign tag_byte = tag_q ? `B_EVEN : `B_ODD;

  // ==========================================================
  // Frame builder
  always_comb begin
    nb       = 8'h00;
    nv       = 1'b0;
    ns       = ts_q;
    cov      = 1'b0;
    pop      = 1'b0;
    rsp_sent = 1'b0;
    rt_step  = 1'b0;
    start    = 1'b0;
    // Responses only at header boundaries, never mid-escape
    if (resp_pend_q && ts_q inside {T_IDLE, T_TAG, T_RTH, T_RTL}) begin
      nb = `B_DLE;
      nv = 1'b1;
      ns = T_RSP;
    end else begin
      case (ts_q)
        T_IDLE: begin
          if (fv && !outstanding_q) begin
            nb    = `B_DLE;
            nv    = 1'b1;
            ns    = T_SOH;
            start = 1'b1;
          end
        end
        T_RSP: begin
          nb       = resp_code_q;
          nv       = 1'b1;
          ns       = ret_q;
          rsp_sent = 1'b1;
        end
        T_SOH: begin
          nb = `B_SOH;
          nv = 1'b1;
          ns = T_TAG;
        end
        T_TAG: begin
          nb  = tag_byte;
          nv  = 1'b1;
          cov = 1'b1;
          ns  = (rcnt_q != 4'h0) ? T_RTH : T_STX0;
        end
        T_RTH: begin
          nb  = hex_char(rte_q[rt_idx_q*8+4 +: 4]);
          nv  = 1'b1;
          cov = 1'b1;
          ns  = T_RTL;
        end
        T_RTL: begin
          nb      = hex_char(rte_q[rt_idx_q*8 +: 4]);
          nv      = 1'b1;
          cov     = 1'b1;
          rt_step = 1'b1;
          ns      = (4'(rt_idx_q + 1'b1) == rcnt_q) ? T_STX0 : T_RTH;
        end
        T_STX0: begin
          nb  = `B_DLE;
          nv  = 1'b1;
          cov = 1'b1;
          ns  = T_STX;
        end
        T_STX: begin
          nb  = `B_STX;
          nv  = 1'b1;
          cov = 1'b1;
          ns  = T_DAT;
        end
        T_DAT: begin
          if (fv) begin
            nv  = 1'b1;
            cov = 1'b1;
            if (fw.data == `B_DLE) begin
              nb = `B_DLE;
              ns = T_ESC;
            end else begin
              nb  = fw.data;
              pop = 1'b1;
              ns  = fw.last ? T_ETX0 : T_DAT;
            end
          end
        end
        T_ESC: begin
          nb  = `B_DLE;
          nv  = 1'b1;
          cov = 1'b1;
          pop = 1'b1;
          ns  = fw.last ? T_ETX0 : T_DAT;
        end
        T_ETX0: begin
          nb  = `B_DLE;
          nv  = 1'b1;
          cov = 1'b1;
          ns  = T_ETX;
        end
        T_ETX: begin
          nb  = `B_ETX;
          nv  = 1'b1;
          cov = 1'b1;
          ns  = T_CSUM;
        end
        T_CSUM: begin
          nb = 8'(`SUM_ZERO - tsum);
          nv = 1'b1;
          ns = T_PAD;
        end
        T_PAD: begin
          nb = `B_PAD;
          nv = 1'b1;
          ns = T_IDLE;
        end
        default: ns = T_IDLE;
      endcase
    end
  end

  csum_acc u_tsum (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (step && start),
    .add     (step && cov),
    .din     (nb),
    .sum_q   (tsum)
  );

  // ==========================================================
  // Builder state and output byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ts_q       <= T_IDLE;
      ret_q      <= T_IDLE;
      tx_byte_q  <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      if (step) begin
        ts_q       <= ns;
        tx_byte_q  <= nb;
        tx_valid_q <= 1'b1;
        if (ns == T_RSP) begin
          ret_q <= ts_q;
        end
      end else if (tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // Route latched at frame start so a changing input cannot split a frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rte_q    <= '0;
      rcnt_q   <= 4'h0;
      rt_idx_q <= 4'h0;
    end else begin
      if (step && start) begin
        rte_q    <= route_drops;
        rcnt_q   <= (route_cnt > 4'(MAX_DROPS)) ? 4'(MAX_DROPS) : route_cnt;
        rt_idx_q <= 4'h0;
      end else if (step && rt_step) begin
        rt_idx_q <= 4'(rt_idx_q + 1'b1);
      end
    end
  end

  // ==========================================================
  // Frame parser
  always_comb begin
    r_ns     = rs_q;
    esc_d    = esc_q;
    fail     = 1'b0;
    good     = 1'b0;
    hold     = 1'b0;
    dv       = 1'b0;
    rsp_seen = 1'b0;
    qry      = 1'b0;
    radd     = 1'b0;
    rclr     = 1'b0;
    rtag_d   = rtag_q;
    if (rx_valid) begin
      if (rx_fault) begin
        fail  = rs_q != R_IDLE;
        esc_d = 1'b0;
      end else if (rs_q == R_CSUM) begin
        good = 8'(rsum + rx_byte) == `SUM_ZERO;
        fail = !good;
        r_ns = R_IDLE;
      end else if (esc_q) begin
        esc_d = 1'b0;
        case (rx_byte)
          `B_SOH: begin
            r_ns = R_TAG;
            rclr = 1'b1;
          end
          `B_STX: begin
            if (rs_q == R_ROUTE && !rtc_q[0]) begin
              r_ns = R_DATA;
              radd = 1'b1;
            end else begin
              fail = rs_q != R_IDLE;
            end
          end
          `B_ETX: begin
            if (rs_q == R_DATA) begin
              r_ns = R_CSUM;
              radd = 1'b1;
            end else begin
              fail = rs_q != R_IDLE;
            end
          end
          `B_DLE: begin
            if (rs_q == R_DATA) begin
              dv   = 1'b1;
              radd = 1'b1;
            end else begin
              fail = rs_q != R_IDLE;
            end
          end
          `B_ODD, `B_EVEN, `B_NAK, `B_SYN: rsp_seen = 1'b1;
          `B_ENQ: begin
            qry  = rs_q == R_IDLE;
            fail = rs_q != R_IDLE;
          end
          default: fail = rs_q != R_IDLE;
        endcase
      end else if (rx_byte == `B_DLE) begin
        esc_d = 1'b1;
      end else begin
        case (rs_q)
          R_TAG: begin
            if (rx_byte == `B_ODD || rx_byte == `B_EVEN) begin
              rtag_d = rx_byte == `B_EVEN;
              radd   = 1'b1;
              r_ns   = R_ROUTE;
            end else begin
              fail = 1'b1;
            end
          end
          R_ROUTE: begin
            radd = 1'b1;
            fail = !is_hex(rx_byte) || rtc_q >= 5'(2*MAX_DROPS);
          end
          R_DATA: begin
            dv   = 1'b1;
            radd = 1'b1;
            fail = rlen_q >= 9'(MAX_DATA);
          end
          default: r_ns = R_IDLE;
        endcase
      end
    end
    if (fail) begin
      r_ns = R_IDLE;
    end else if (!good && hold_req && rs_q != R_IDLE) begin
      hold = 1'b1;
      r_ns = R_IDLE;
    end
  end

  assign rdin = esc_q ? 8'(`B_DLE + rx_byte) : rx_byte;

  csum_acc u_rsum (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (rclr),
    .add     (radd && !fail),
    .din     (rdin),
    .sum_q   (rsum)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rs_q        <= R_IDLE;
      esc_q       <= 1'b0;
      rtag_q      <= 1'b0;
      rtc_q       <= 5'h00;
      rlen_q      <= 9'h000;
      rcv_data_q  <= 8'h00;
      rcv_valid_q <= 1'b0;
      rcv_end_q   <= 1'b0;
      rcv_good_q  <= 1'b0;
    end else begin
      rs_q        <= r_ns;
      esc_q       <= esc_d;
      rtag_q      <= rtag_d;
      rcv_valid_q <= dv && !fail;
      rcv_end_q   <= good || fail || hold;
      rcv_good_q  <= good;
      if (dv) begin
        rcv_data_q <= rx_byte;
      end
      if (rclr) begin
        rtc_q  <= 5'h00;
        rlen_q <= 9'h000;
      end else begin
        if (radd && rs_q == R_ROUTE) rtc_q <= 5'(rtc_q + 1'b1);
        if (dv) rlen_q <= 9'(rlen_q + 1'b1);
      end
    end
  end

  // ==========================================================
  // Response scheduling; a new event beats the clear
  assign rsp_set = fail || hold || good || qry;
  assign rsp_new = fail ? `B_NAK : hold ? `B_SYN :
                   good ? (rtag_q ? `B_EVEN : `B_ODD) : last_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp_pend_q <= 1'b0;
      resp_code_q <= `B_NAK;
      last_q      <= `B_NAK;
    end else begin
      if (rsp_set) begin
        resp_pend_q <= 1'b1;
        resp_code_q <= rsp_new;
        last_q      <= rsp_new;
      end else if (step && rsp_sent) begin
        resp_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outstanding frame and answers from the peer
  // No teardown: state stays in data transfer until reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outstanding_q <= 1'b0;
      tag_q         <= 1'b0;
      tx_done_q     <= 1'b0;
      tx_rejected_q <= 1'b0;
      tx_held_q     <= 1'b0;
    end else begin
      tx_done_q     <= 1'b0;
      tx_rejected_q <= 1'b0;
      tx_held_q     <= 1'b0;
      if (rsp_seen && outstanding_q) begin
        outstanding_q <= 1'b0;
        if (rx_byte == tag_byte) begin
          tx_done_q <= 1'b1;
          tag_q     <= !tag_q;
        end else if (rx_byte == `B_SYN) begin
          tx_held_q <= 1'b1;
        end else begin
          tx_rejected_q <= 1'b1;
        end
      end
      if (step && ts_q == T_PAD) begin
        outstanding_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  soh_open_a: assert property (step && ts_q == T_SOH |=> tx_byte_q == `B_SOH && $past(tx_byte_q) == `B_DLE) else $error("bad header open");
  tag_flip_a: assert property ($changed(tag_q) |-> tx_done_q) else $error("tag flip without ack");
  stx_seq_a: assert property (step && ts_q == T_STX0 |=> ##[0:300] tx_byte_q == `B_STX) else $error("text open missing");
  dle_stuff_a: assert property (step && ts_q == T_ESC |-> tx_byte_q == `B_DLE) else $error("escape not doubled");
  csum_value_a: assert property (step && ts_q == T_CSUM |=> 8'(tx_byte_q + tsum) == `SUM_ZERO) else $error("bad checksum");
  pad_follow_a: assert property (step && ts_q == T_PAD |=> tx_byte_q == `B_PAD && outstanding_q) else $error("filler missing");
  rsp_place_a: assert property (ts_q == T_RSP |-> ret_q inside {T_IDLE, T_TAG, T_RTH, T_RTL}) else $error("response misplaced");
  ack_tag_a: assert property (good |=> resp_pend_q && resp_code_q == ($past(rtag_q) ? `B_EVEN : `B_ODD)) else $error("ack tag wrong");
  nak_on_fail_a: assert property (fail |=> resp_pend_q && resp_code_q == `B_NAK && rcv_end_q && !rcv_good_q) else $error("reject missing");
  route_hex_a: assert property (step && ts_q inside {T_RTH, T_RTL} |=> is_hex(tx_byte_q)) else $error("route digit not hex");
endmodule // p2p_link_frame_codec

// [dv/peer_station.sv]
`timescale 1ns/100ps
module peer_station (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Codec transmit side
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       stall,
  // Codec receive side
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_fault
);
  // ==========================================================
  // Byte sink; stall stands in for a slow UART
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !stall;
    end
  end

  // ==========================================================
  // Byte source; no stale byte left on the line between strobes
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    rx_fault = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    @(posedge clk_sys);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge clk_sys);
    rx_byte  <= ~b;
    rx_valid <= 1'b0;
  endtask

  // Byte flagged with a line error, as a UART reports it
  task automatic put_bad(input logic [7:0] b);
    @(posedge clk_sys);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    rx_fault <= 1'b1;
    @(posedge clk_sys);
    rx_byte  <= ~b;
    rx_valid <= 1'b0;
    rx_fault <= 1'b0;
  endtask

  // Answer to an outgoing frame; wrong tags only when asked
  task automatic respond(input logic [7:0] code);
    put(8'h10);
    put(code);
  endtask

  // Ask for the last answer again; the codec answers it only on an idle line
  task automatic query();
    put(8'h10);
    put(8'h05);
  endtask
endmodule // peer_station

// [dv/test_p2p_link_frame_codec.sv]
`timescale 1ns/100ps
module test_p2p_link_frame_codec import link_pkg::*;;
  // ==========================================================
  // Stimulus and observation
  logic        clk_sys = 1'b0;
  logic        rst, snd_valid, hold_req, stall;
  snd_word_s   snd_word;
  logic [63:0] route_drops, drops;
  logic [3:0]  route_cnt;
  logic        snd_ready, outstanding_q, tx_done_q, tx_rejected_q, tx_held_q;
  logic        tx_valid_q, tx_ready, rx_valid, rx_fault, rcv_valid_q, rcv_end_q, rcv_good_q;
  logic [7:0]  tx_byte_q, rx_byte, rcv_data_q, sum;
  logic [7:0]  exp_tx[$], exp_rx[$], dat[$];
  logic        exp_good[$];
  logic        refused;
  logic [31:0] rng = 32'hAA03;
  int          error_cnt = 0, n_compared = 0;

  always #12.5 clk_sys = ~clk_sys;

  p2p_link_frame_codec u_dut (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .snd_valid     (snd_valid),
    .snd_ready     (snd_ready),
    .snd_word      (snd_word),
    .route_drops   (route_drops),
    .route_cnt     (route_cnt),
    .outstanding_q (outstanding_q),
    .tx_done_q     (tx_done_q),
    .tx_rejected_q (tx_rejected_q),
    .tx_held_q     (tx_held_q),
    .tx_byte_q     (tx_byte_q),
    .tx_valid_q    (tx_valid_q),
    .tx_ready      (tx_ready),
    .rx_byte       (rx_byte),
    .rx_valid      (rx_valid),
    .rx_fault      (rx_fault),
    .hold_req      (hold_req),
    .rcv_data_q    (rcv_data_q),
    .rcv_valid_q   (rcv_valid_q),
    .rcv_end_q     (rcv_end_q),
    .rcv_good_q    (rcv_good_q)
  );

  peer_station u_peer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .tx_byte  (tx_byte_q),
    .tx_valid (tx_valid_q),
    .tx_ready (tx_ready),
    .stall    (stall),
    .rx_byte  (rx_byte),
    .rx_valid (rx_valid),
    .rx_fault (rx_fault)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic px(input logic [7:0] b, input logic add);
    exp_tx.push_back(b);
    if (add) begin
      sum = sum + b;
    end
  endtask

  task automatic mk(input int n);
    dat.delete();
    repeat (n) begin
      rng = xs(rng);
      dat.push_back(rng[7:0]);
    end
    dat[n / 2] = 8'h10;
  endtask

  // Expected outgoing frame from dat and drops
  task automatic frame_exp(input logic [7:0] tag, input int nd);
    sum = 8'h00;
    px(8'h10, 1'b0);
    px(8'h01, 1'b0);
    px(tag, 1'b1);
    for (int i = 0; i < nd; i++) begin
      px(hexc(drops[8*i+4 +: 4]), 1'b1);
      px(hexc(drops[8*i +: 4]), 1'b1);
    end
    px(8'h10, 1'b1);
    px(8'h02, 1'b1);
    foreach (dat[i]) begin
      if (dat[i] == 8'h10) begin
        px(8'h10, 1'b1);
      end
      px(dat[i], 1'b1);
    end
    px(8'h10, 1'b1);
    px(8'h03, 1'b1);
    px(8'h00 - sum, 1'b0);
    px(8'hFE, 1'b0);
  endtask

  // Offer every word; watch for refusal while waiting
  task automatic send_frame();
    int k;
    foreach (dat[i]) begin
      snd_valid <= 1'b1;
      snd_word  <= '{last: (i == dat.size() - 1), data: dat[i]};
      k = 0;
      do begin
        @(negedge clk_sys);
        refused = refused | (snd_ready === 1'b0);
        k++;
      end while (snd_ready !== 1'b1 && k < 4000);
      if (k >= 4000) begin
        error_cnt++;
      end
      @(posedge clk_sys);
    end
    snd_valid <= 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((exp_tx.size() + exp_rx.size() + exp_good.size()) > 0 && k < 4000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 4000) begin
      error_cnt++;
    end
    repeat (4) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask

  task automatic outcome(input logic [2:0] exp);
    int k;
    k = 0;
    // Look off the edge that launches the pulse
    do begin
      @(negedge clk_sys);
      k++;
    end while (!(tx_done_q | tx_rejected_q | tx_held_q) && k < 40);
    chk("outcome", {13'h0, tx_done_q, tx_rejected_q, tx_held_q}, {13'h0, exp});
    @(posedge clk_sys);
  endtask

  // Peer sends a data frame; bad spoils the checksum
  task automatic rx_frame(input logic [7:0] tag, input logic bad);
    logic [7:0] s;
    s = tag + 8'h25;
    u_peer.put(8'h10);
    u_peer.put(8'h01);
    u_peer.put(tag);
    u_peer.put(8'h10);
    u_peer.put(8'h02);
    foreach (dat[i]) begin
      if (dat[i] == 8'h10) begin
        u_peer.put(8'h10);
        s = s + 8'h10;
      end
      u_peer.put(dat[i]);
      s = s + dat[i];
      exp_rx.push_back(dat[i]);
    end
    u_peer.put(8'h10);
    u_peer.put(8'h03);
    u_peer.put(8'h00 - s + {7'h0, bad});
    exp_good.push_back(!bad);
    exp_tx.push_back(8'h10);
    exp_tx.push_back(bad ? 8'h15 : tag);
  endtask

  // ==========================================================
  // Output watcher; handshakes settle before the falling edge
  always @(negedge clk_sys) begin
    if (!rst && tx_valid_q && tx_ready) begin
      if (exp_tx.size() == 0) begin
        chk("tx_extra", {8'h0, tx_byte_q}, 16'hFFFF);
      end else begin
        chk("tx_byte", {8'h0, tx_byte_q}, {8'h0, exp_tx.pop_front()});
      end
    end
    if (!rst && rcv_valid_q) begin
      chk("rcv_data", {8'h0, rcv_data_q}, {8'h0, exp_rx.pop_front()});
    end
    if (!rst && rcv_end_q) begin
      chk("rcv_good", {15'h0, rcv_good_q}, {15'h0, exp_good.pop_front()});
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  // ==========================================================
  // Scenarios
  initial begin
    rst         = 1'b1;
    snd_valid   = 1'b0;
    hold_req    = 1'b0;
    stall       = 1'b0;
    snd_word    = '0;
    route_drops = '0;
    route_cnt   = 4'h0;
    refused = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Minimal frame, matching acknowledge
    drops = '0;
    dat = '{8'h41};
    frame_exp(8'h11, 0);
    send_frame();
    drain();
    chk("outstanding", {15'h0, outstanding_q}, 16'h0001);
    u_peer.respond(8'h11);
    outcome(3'b100);
    chk("outstanding", {15'h0, outstanding_q}, 16'h0000);
    // Two drops, FIFO filled against a stalled sink, wrong-tag answer
    drops = {xs(rng), xs(xs(rng))};
    route_drops <= drops;
    route_cnt <= 4'h2;
    stall <= 1'b1;
    mk(20);
    frame_exp(8'h12, 2);
    fork
      begin
        repeat (150) @(posedge clk_sys);
        stall <= 1'b0;
      end
    join_none
    send_frame();
    chk("refused", {15'h0, refused}, 16'h0001);
    drain();
    u_peer.respond(8'h11);
    outcome(3'b010);
    // Eight drops, hold-off, then a stray acknowledge
    route_cnt <= 4'h8;
    mk(3);
    frame_exp(8'h12, 8);
    send_frame();
    drain();
    u_peer.respond(8'h16);
    outcome(3'b001);
    u_peer.respond(8'h12);
    outcome(3'b000);
    // Good incoming frame, then a query
    mk(4);
    rx_frame(8'h11, 1'b0);
    drain();
    u_peer.query();
    exp_tx.push_back(8'h10);
    exp_tx.push_back(8'h11);
    drain();
    // Bad checksum on an incoming frame, answered with a reject
    mk(5);
    rx_frame(8'h12, 1'b1);
    drain();
    // Line error on the tag byte
    u_peer.put(8'h10);
    u_peer.put(8'h01);
    u_peer.put_bad(8'h11);
    exp_good.push_back(1'b0);
    exp_tx.push_back(8'h10);
    exp_tx.push_back(8'h15);
    drain();
    dat = '{8'h41};
    exp_rx.push_back(8'h41);
    u_peer.put(8'h10);
    u_peer.put(8'h01);
    u_peer.put(8'h12);
    u_peer.put(8'h10);
    u_peer.put(8'h02);
    u_peer.put(8'h41);
    exp_good.push_back(1'b0);
    exp_tx.push_back(8'h10);
    exp_tx.push_back(8'h16);
    hold_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hold_req <= 1'b0;
    drain();
    complete_run();
  end
endmodule // test_p2p_link_frame_codec
